/* rtl/eeprom_cmd_ctrl.sv */
`timescale 1ns/1ps
// Operation
// R01 - Write only on stop right after data ack
// R02 - Start aborts command being received
// R03 - No instruction acknowledged during initialisation
// R04 - Initialise automatically, no reset pin needed
// R05 - After initialisation wait idle for start
// R06 - Master clocks device off low SDA first
// R07 - Master uses random read after cancel
// R08 - Master checks acknowledge after each byte
// R09 - Master runs recovery if init unsure
// R10 - Recovery: start, nine clocks, start, stop
// R11 - Dummy write loads address, no write
// R12 - Any start releases SDA, expects device address
module eeprom_cmd_ctrl
  import eeprom_cmd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = eeprom_cmd_pkg::DEV_ADDR_DEF,
  parameter int INIT_CYC = eeprom_cmd_pkg::INIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [7:0] rd_data,
  output logic rd_next,
  output logic wr_valid,
  output eeprom_cmd_pkg::wr_word_type wr_word,
  input wire logic wr_ready,
  output logic wr_commit,
  output logic wr_abort,
  output logic standby
);
  import eeprom_cmd_pkg::*;

  localparam int ICW = $clog2(INIT_CYC + 1);
  localparam logic [ICW-1:0] INIT_LAST = ICW'(INIT_CYC - 1);

  state_type state_ff;
  state_type after_ack_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [3:0] bits_ff;
  logic [7:0] waddr_ff;
  logic [ICW-1:0] init_cnt_ff;
  logic ack_drv_ff;
  logic got_data_ff;
  logic ack_last_ff;
  logic mack_ff;
  logic sda_out_ff;
  logic sda_oe_n_ff;
  logic rd_next_ff;
  logic push_ff;
  wr_word_type push_word_ff;
  logic commit_ff;
  logic abort_ff;
  logic standby_ff;
  logic fifo_ready;
  logic rw_read_ff;

  wire scl_rise = scl && !scl_prev_ff;
  wire scl_fall = !scl && scl_prev_ff;
  wire start_ev = scl && scl_prev_ff && sda_prev_ff && !sda_in;
  wire stop_ev = scl && scl_prev_ff && !sda_prev_ff && sda_in;
  wire [7:0] byte_in = {shift_ff[6:0], sda_in};
  wire byte_done = scl_rise && (bits_ff == BIT_LAST);
  wire dev_match = byte_in[7:1] == DEV_ADDR;
  wire in_write = (state_ff == st_rx_word) || (state_ff == st_rx_data) ||
                  ((state_ff == st_ack_out) && !rw_read_ff);
  // Stop counts only if no SCL fall came since the data ack ended;
  // a stop needs one SCL rise of its own, so that rise is allowed
  wire commit_ok = (state_ff == st_rx_data) && got_data_ff && ack_last_ff;

  assign sda_out = sda_out_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign rd_next = rd_next_ff;
  assign wr_commit = commit_ff;
  assign wr_abort = abort_ff;
  assign standby = standby_ff;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl;
      sda_prev_ff <= sda_in;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff <= st_init; // [R04]
      after_ack_ff <= st_idle;
      shift_ff <= '0;
      tx_ff <= '0;
      bits_ff <= '0;
      waddr_ff <= '0;
      init_cnt_ff <= '0;
      ack_drv_ff <= 1'b0;
      got_data_ff <= 1'b0;
      ack_last_ff <= 1'b0;
      mack_ff <= 1'b0;
      rw_read_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      rd_next_ff <= 1'b0;
      push_ff <= 1'b0;
      push_word_ff <= '0;
      commit_ff <= 1'b0;
      abort_ff <= 1'b0;
      standby_ff <= 1'b0;
    end else begin
      rd_next_ff <= 1'b0;
      push_ff <= 1'b0;
      commit_ff <= 1'b0;
      abort_ff <= 1'b0;
      if (state_ff == st_init) begin
        // Bus is not watched at all until the count runs out
        sda_oe_n_ff <= 1'b1; // [R03]
        if (init_cnt_ff == INIT_LAST) begin
          state_ff <= st_idle; // [R05]
          standby_ff <= 1'b1;
        end else begin
          init_cnt_ff <= init_cnt_ff + 1'b1;
        end
      end else if (start_ev) begin
        abort_ff <= in_write && got_data_ff; // [R02]
        state_ff <= st_rx_dev; // [R12]
        sda_oe_n_ff <= 1'b1; // [R12]
        bits_ff <= '0;
        ack_drv_ff <= 1'b0;
        got_data_ff <= 1'b0;
        ack_last_ff <= 1'b0;
      end else if (stop_ev) begin
        commit_ff <= commit_ok; // [R01]
        abort_ff <= in_write && got_data_ff && !commit_ok; // [R01]
        state_ff <= st_idle;
        sda_oe_n_ff <= 1'b1;
        got_data_ff <= 1'b0;
        ack_last_ff <= 1'b0;
      end else begin
        if (scl_rise) begin
          shift_ff <= byte_in;
        end
        case (state_ff)
          st_rx_dev: begin
            if (scl_rise) begin
              bits_ff <= bits_ff + 1'b1;
            end
            if (byte_done) begin
              rw_read_ff <= sda_in;
              state_ff <= dev_match ? st_ack_out : st_ignore;
              after_ack_ff <= (sda_in == RW_READ) ? st_tx_data : st_rx_word;
            end
          end
          st_rx_word: begin
            if (scl_rise) begin
              bits_ff <= bits_ff + 1'b1;
            end
            if (byte_done) begin
              // Dummy write ends here; nothing is queued yet
              waddr_ff <= byte_in; // [R11]
              state_ff <= st_ack_out;
              after_ack_ff <= st_rx_data;
            end
          end
          st_rx_data: begin
            if (scl_rise) begin
              bits_ff <= bits_ff + 1'b1;
            end
            if (scl_fall) begin
              ack_last_ff <= 1'b0; // [R01]
            end
            if (byte_done) begin
              // A full queue refuses the byte by withholding the ack
              if (fifo_ready) begin
                push_ff <= 1'b1;
                push_word_ff <= '{addr: waddr_ff, data: byte_in};
                waddr_ff <= waddr_ff + 1'b1;
                got_data_ff <= 1'b1; // [R01]
                state_ff <= st_ack_out;
                after_ack_ff <= st_rx_data;
              end else begin
                state_ff <= st_ignore;
              end
            end
          end
          st_ack_out: begin
            if (scl_fall) begin
              if (!ack_drv_ff) begin
                ack_drv_ff <= 1'b1;
                sda_oe_n_ff <= 1'b0;
              end else begin
                ack_drv_ff <= 1'b0;
                bits_ff <= '0;
                state_ff <= after_ack_ff;
                ack_last_ff <= after_ack_ff == st_rx_data; // [R01]
                if (after_ack_ff == st_tx_data) begin
                  tx_ff <= rd_data;
                  sda_oe_n_ff <= rd_data[7];
                end else begin
                  sda_oe_n_ff <= 1'b1;
                end
              end
            end
          end
          st_tx_data: begin
            if (scl_rise) begin
              bits_ff <= bits_ff + 1'b1;
            end
            if (scl_fall) begin
              if (bits_ff == BIT_COUNT) begin
                sda_oe_n_ff <= 1'b1;
                state_ff <= st_ack_in;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                sda_oe_n_ff <= tx_ff[6];
              end
            end
          end
          st_ack_in: begin
            if (scl_rise) begin
              mack_ff <= !sda_in;
              rd_next_ff <= 1'b1;
            end
            if (scl_fall) begin
              bits_ff <= '0;
              if (mack_ff) begin
                tx_ff <= rd_data;
                sda_oe_n_ff <= rd_data[7];
                state_ff <= st_tx_data;
              end else begin
                state_ff <= st_ignore;
              end
            end
          end
          st_idle, st_ignore: begin
            sda_oe_n_ff <= 1'b1;
          end
          default: begin
            state_ff <= st_idle;
          end
        endcase
      end
    end
  end

  wr_fifo #(
    .WIDTH($bits(wr_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(push_ff),
    .in_data(push_word_ff),
    .in_ready(fifo_ready),
    .out_valid(wr_valid),
    .out_data(wr_word),
    .out_ready(wr_ready)
  );
endmodule

/* rtl/eeprom_cmd_pkg.sv */
package eeprom_cmd_pkg;
  localparam int CLK_MHZ = 250;
  // Power-on initialisation time in ns; the count rounds up to whole cycles
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic RW_READ = 1'b1;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_type;

  typedef enum {
    st_init,
    st_idle,
    st_rx_dev,
    st_rx_word,
    st_rx_data,
    st_ack_out,
    st_tx_data,
    st_ack_in,
    st_ignore
  } state_type;
endpackage

/* rtl/wr_fifo.sv */
`timescale 1ns/1ps
module wr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;

  assign in_ready = count_ff != FULL_COUNT;
  assign out_valid = count_ff != '0;
  assign out_data = mem_ff[rd_ptr_ff];

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= step(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= step(rd_ptr_ff);
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

/* tb/eeprom_cmd_monitor.sv */
`timescale 1ns/1ps
module eeprom_cmd_monitor
  import eeprom_cmd_pkg::*;
#(
  parameter int INIT_CYC = 500
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] rd_data,
  input wire logic rd_next,
  input wire logic wr_valid,
  input wire eeprom_cmd_pkg::wr_word_type wr_word,
  input wire logic wr_ready,
  input wire logic wr_commit,
  input wire logic wr_abort,
  input wire logic standby
);
  logic scl_ff, sda_ff;
  logic [15:0] cnt_ff;
  wire start_seen = scl && scl_ff && sda_ff && !sda_in;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    scl_ff <= scl;
    sda_ff <= sda_in;
  end
  // Saturates so a long run cannot wrap into the init window
  always_ff @(posedge clock) begin
    if (!nrst) cnt_ff <= '0;
    else if (cnt_ff != 16'hffff) cnt_ff <= cnt_ff + 16'h0001;
  end
  property p_quiet_init; !standby |-> sda_oe_n; endproperty
  a_quiet_init: assert property (p_quiet_init) else $error("bus driven before standby");
  property p_init_len; standby |-> cnt_ff >= 16'(INIT_CYC); endproperty
  a_init_len: assert property (p_init_len) else $error("standby too early");
  property p_init_end; !standby |-> cnt_ff <= 16'(INIT_CYC + 8); endproperty
  a_init_end: assert property (p_init_end) else $error("standby too late");
  property p_commit_stop; wr_commit |-> scl && sda_in && !wr_abort; endproperty
  a_commit_stop: assert property (p_commit_stop) else $error("commit without stop");
  property p_commit_once; wr_commit |=> !wr_commit; endproperty
  a_commit_once: assert property (p_commit_once) else $error("commit longer than one cycle");
  property p_start_rel; start_seen |-> sda_oe_n[*4]; endproperty
  a_start_rel: assert property (p_start_rel) else $error("data line held after start");
  property p_start_nocommit; start_seen |-> !wr_commit[*4]; endproperty
  a_start_nocommit: assert property (p_start_nocommit) else $error("commit on start");
  property p_abort_once; wr_abort |=> !wr_abort; endproperty
  a_abort_once: assert property (p_abort_once) else $error("abort longer than one cycle");
  property p_drive_low; $fell(sda_oe_n) |-> !scl && standby; endproperty
  a_drive_low: assert property (p_drive_low) else $error("data line pulled at bad time");
endmodule

/* tb/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model #(
  parameter int HP = 4
) (
  input wire logic clock,
  output logic scl,
  output logic sda_m,
  input wire logic sda_w
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt();
    repeat (HP) @(posedge clock);
  endtask
  // Data moves only while the clock is low, so no false start or stop
  task automatic clk_bit(input logic b, output logic r);
    sda_m <= b;
    wt();
    scl <= 1'b1;
    wt();
    r = sda_w;
    scl <= 1'b0;
    wt();
  endtask
  task automatic start_c();
    sda_m <= 1'b1;
    wt();
    scl <= 1'b1;
    wt();
    sda_m <= 1'b0;
    wt();
    scl <= 1'b0;
    wt();
  endtask
  task automatic stop_c();
    sda_m <= 1'b0;
    wt();
    scl <= 1'b1;
    wt();
    sda_m <= 1'b1;
    wt();
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) clk_bit(tx[i], rx[i]);
  endtask
  task automatic recover();
    logic [8:0] rx;
    start_c();
    xfer(9'h1ff, rx);
    start_c();
    stop_c();
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import eeprom_cmd_pkg::*;
  localparam logic [7:0] DEVW = {DEV_ADDR_DEF, 1'b0};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] rd_data = 8'h5a;
  logic wr_ready = 1'b0;
  logic scl, sda_m, sda_out, sda_oe_n, rd_next, wr_valid, wr_commit, wr_abort, standby;
  wr_word_type wr_word;
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  int num_errors = 0, comparisons = 0, commits = 0, aborts = 0;
  logic [8:0] rx;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    commits += wr_commit;
    aborts += wr_abort;
    if (rd_next) rd_data <= rd_data + 8'h01;
  end
  eeprom_cmd_ctrl #(.INIT_CYC(200)) eeprom_cmd_ctrl_inst (.clock, .nrst, .scl, .sda_in(sda_w),
    .sda_out, .sda_oe_n, .rd_data, .rd_next, .wr_valid, .wr_word, .wr_ready, .wr_commit,
    .wr_abort, .standby);
  bus_master_model bus_master_model_inst (.clock, .scl, .sda_m, .sda_w);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic ack);
    bus_master_model_inst.xfer({d, 1'b1}, rx);
    chk("ack", 16'(!ack), 16'(rx[0]));
  endtask
  task automatic drain(input int n);
    int cnt = 0;
    wr_ready <= 1'b1;
    repeat (40) @(posedge clock) cnt += wr_valid;
    wr_ready <= 1'b0;
    chk("pops", 16'(n), 16'(cnt));
  endtask
  task automatic t_init();
    bus_master_model_inst.start_c();
    wb(DEVW, 1'b0);
    chk("standby", 16'h0000, 16'(standby));
    bus_master_model_inst.stop_c();
    for (int i = 0; i < 300 && standby !== 1'b1; i++) @(posedge clock);
    chk("standby", 16'h0001, 16'(standby));
  endtask
  task automatic t_write(input logic extra);
    int c = commits, a = aborts;
    bus_master_model_inst.start_c();
    wb(DEVW, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h34, 1'b1);
    if (extra) bus_master_model_inst.clk_bit(1'b1, rx[0]);
    bus_master_model_inst.stop_c();
    repeat (4) @(posedge clock);
    chk("commit", 16'(!extra), 16'(commits - c));
    chk("abort", 16'(extra), 16'(aborts - a));
    chk("word", 16'h1234, wr_word);
    drain(1);
  endtask
  task automatic t_cancel();
    int c = commits, a = aborts;
    bus_master_model_inst.start_c();
    wb(DEVW, 1'b1);
    wb(8'h20, 1'b1);
    wb(8'h77, 1'b1);
    bus_master_model_inst.start_c();
    wb(DEVW, 1'b1);
    wb(8'h20, 1'b1);
    bus_master_model_inst.start_c();
    wb(DEVW | 8'h01, 1'b1);
    bus_master_model_inst.xfer(9'h1ff, rx);
    bus_master_model_inst.stop_c();
    repeat (4) @(posedge clock);
    chk("read", 16'h005a, 16'(rx[8:1]));
    chk("rd_next", 16'h005b, 16'(rd_data));
    chk("abort", 16'h0001, 16'(aborts - a));
    chk("commit", 16'h0000, 16'(commits - c));
    drain(1);
  endtask
  task automatic t_full();
    int c = commits;
    bus_master_model_inst.start_c();
    wb(DEVW, 1'b1);
    wb(8'h00, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) wb(8'(i), 1'b1);
    wb(8'hee, 1'b0);
    bus_master_model_inst.stop_c();
    repeat (4) @(posedge clock);
    chk("commit", 16'h0000, 16'(commits - c));
    drain(FIFO_DEPTH);
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_init();
    bus_master_model_inst.recover();
    t_write(1'b0);
    t_write(1'b1);
    t_cancel();
    t_full();
    give_verdict();
  end
  // Whole sequence needs about 4150 cycles
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule
bind eeprom_cmd_ctrl eeprom_cmd_monitor #(.INIT_CYC(INIT_CYC)) eeprom_cmd_monitor_inst (.clock,
  .nrst, .scl, .sda_in, .sda_out, .sda_oe_n, .rd_data, .rd_next, .wr_valid, .wr_word,
  .wr_ready, .wr_commit, .wr_abort, .standby);
